// ==== body_pkg.sv ====
package body_pkg;
    localparam int unsigned clk_hz = 200_000_000;
    localparam int unsigned ms_per_s = 1000;
    // times in milliseconds, cycles derived from the clock rate
    localparam int unsigned mist_limit_ms = 600;
    localparam int unsigned wipe_cycle_ms = 1200;
    localparam int unsigned after_wash_ms = 3000;
    localparam int unsigned arm_light_ms = 20000;
    localparam int unsigned alarm_ms = 180000;
    localparam int unsigned horn_half_ms = 500;
    localparam int unsigned debounce_ms = 10;
    localparam int unsigned cyc_per_ms = clk_hz / ms_per_s;
    localparam int unsigned tick_div = cyc_per_ms;
    localparam int unsigned tick_w = 18;
    localparam int unsigned ms_w = 18;
    localparam int unsigned n_sw = 11;

    typedef struct packed {
        logic ign_run;
        logic ignition_aux_position;
        logic key_present;
        logic wiper_off;
        logic wiper_periodic;
        logic washer;
        logic door_open;
        logic door_locked;
        logic key_cyl_unlock;
        logic key_cyl_turn;
        logic liftgate_key_unlock;
    } sw_t;

    typedef struct packed {
        logic hood_open;
        logic liftgate_open;
        logic keyless_lock;
        logic key_lock;
    } ev_t;

    typedef struct packed {
        logic horn;
        logic headlights;
        logic starter_block;
        logic arming_indicator;
        logic central_lock_cmd;
    } alarm_out_t;
endpackage

// ==== body_timer_alarm_control.sv ====
`timescale 1ns/1ps
module body_timer_alarm_control
    import body_pkg::*;
#(
    parameter logic [ms_w-1:0] mist_limit_p = ms_w'(mist_limit_ms),
    parameter logic [ms_w-1:0] wipe_cycle_p = ms_w'(wipe_cycle_ms),
    parameter logic [ms_w-1:0] after_wash_p = ms_w'(after_wash_ms),
    parameter logic [ms_w-1:0] arm_light_p = ms_w'(arm_light_ms),
    parameter logic [ms_w-1:0] alarm_p = ms_w'(alarm_ms),
    parameter logic [ms_w-1:0] horn_half_p = ms_w'(horn_half_ms),
    parameter int unsigned tick_div_p = tick_div
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire sw_t sw_raw,
    input wire ev_t ev_raw,
    output logic wiper_drive_output,
    output alarm_out_t alarm_out
);
    typedef enum {w_idle, w_press, w_mist_wait, w_wipe, w_long, w_after} wash_t;
    typedef enum {a_disarmed, a_door_open, a_indicating, a_armed, a_alarm} sec_t;

    logic [tick_w-1:0] div_q;
    logic tick;
    sw_t sw;
    ev_t ev;
    logic [n_sw+3:0] raw_all;
    logic [n_sw+3:0] clean_all;
    ev_t ev_prev_q;
    logic [ms_w-1:0] press_q;
    wash_t wash_q;
    logic [ms_w-1:0] wtmr_q;
    sec_t sec_q;
    logic sec_start;
    logic sec_stop;
    logic [ms_w-1:0] sec_len;
    logic sec_running;
    logic sec_done;
    logic [ms_w-1:0] horn_q;
    logic horn_phase_q;
    logic wash_allowed;
    logic intrusion;
    logic door_ajar_unlock;

    // one-millisecond enable
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            div_q <= '0;
        else if (div_q >= tick_w'(tick_div_p - 1))
            div_q <= '0;
        else
            div_q <= div_q + tick_w'(1);
    end
    assign tick = (div_q == '0);

    assign raw_all = {sw_raw, ev_raw};

    genvar gi;
    generate
        for (gi = 0; gi < n_sw + 4; gi++)
        begin : g_filt
            switch_filter u_filt (
                .clk(clk),
                .arst_n(arst_n),
                .tick(tick),
                .raw(raw_all[gi]),
                .clean(clean_all[gi])
            );
        end
    endgenerate
    assign sw = clean_all[n_sw+3:4];
    assign ev = clean_all[3:0];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ev_prev_q <= '0;
        else
            ev_prev_q <= ev;
    end

    assign wash_allowed = ((sw.ign_run || sw.ignition_aux_position) && sw.wiper_off)
                          || sw.wiper_periodic;

    // washer press measurement and wipe sequencing
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wash_q <= w_idle;
            press_q <= '0;
            wtmr_q <= '0;
        end
        else
        begin
            unique case (wash_q)
                w_idle:
                begin
                    press_q <= '0;
                    if (sw.washer && wash_allowed)
                        wash_q <= w_press;
                end
                w_press:
                begin
                    if (!sw.washer)
                    begin
                        wash_q <= w_mist_wait;
                        wtmr_q <= press_q;
                    end
                    else if (tick)
                    begin
                        if (press_q + ms_w'(1) >= mist_limit_p)
                            wash_q <= w_long;
                        press_q <= press_q + ms_w'(1);
                    end
                end
                w_mist_wait:
                begin
                    if (wtmr_q == '0)
                    begin
                        wash_q <= w_wipe;
                        wtmr_q <= wipe_cycle_p;
                    end
                    else if (tick)
                        wtmr_q <= wtmr_q - ms_w'(1);
                end
                w_wipe:
                begin
                    if (wtmr_q == '0)
                        wash_q <= w_idle;
                    else if (tick)
                        wtmr_q <= wtmr_q - ms_w'(1);
                end
                w_long:
                begin
                    if (!sw.washer)
                    begin
                        wash_q <= w_after;
                        wtmr_q <= after_wash_p;
                    end
                end
                w_after:
                begin
                    if (wtmr_q == '0)
                        wash_q <= w_idle;
                    else if (tick)
                        wtmr_q <= wtmr_q - ms_w'(1);
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            wiper_drive_output <= 1'b0;
        else
            wiper_drive_output <= (wash_q == w_wipe) || (wash_q == w_long)
                                  || (wash_q == w_after);
    end

    assign intrusion = sw.door_open || (ev.hood_open && !ev_prev_q.hood_open)
                       || (ev.liftgate_open && !ev_prev_q.liftgate_open);
    assign door_ajar_unlock = sw.door_open && !sw.door_locked;

    ms_timer u_sec_tmr (
        .clk(clk),
        .arst_n(arst_n),
        .tick(tick),
        .start(sec_start),
        .stop(sec_stop),
        .len_ms(sec_len),
        .running(sec_running),
        .done(sec_done)
    );

    // security sequencer; timer restarts only on state entry
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sec_q <= a_disarmed;
            sec_start <= 1'b0;
            sec_stop <= 1'b0;
            sec_len <= '0;
        end
        else
        begin
            sec_start <= 1'b0;
            sec_stop <= 1'b0;
            unique case (sec_q)
                a_disarmed:
                begin
                    if (!sw.key_present && sw.door_open)
                        sec_q <= a_door_open;
                end
                a_door_open:
                begin
                    if (sw.key_present)
                        sec_q <= a_disarmed;
                    else if (ev.key_lock || ev.keyless_lock)
                    begin
                        if (ev.keyless_lock && sw.door_open)
                            sec_q <= a_disarmed;
                        else if (sw.door_locked)
                        begin
                            sec_q <= a_indicating;
                            sec_start <= 1'b1;
                            sec_len <= arm_light_p;
                        end
                    end
                    else if (door_ajar_unlock && ev_prev_q.key_lock)
                        sec_q <= a_disarmed;
                end
                a_indicating:
                begin
                    // hood and liftgate deliberately not looked at here
                    if (!sw.door_locked || sw.key_cyl_unlock)
                    begin
                        sec_q <= a_disarmed;
                        sec_stop <= 1'b1;
                    end
                    else if (sec_done)
                        sec_q <= a_armed;
                end
                a_armed:
                begin
                    if (sw.key_cyl_unlock || sw.liftgate_key_unlock)
                        sec_q <= a_disarmed;
                    else if (sw.key_present && (sw.ign_run || sw.ignition_aux_position))
                        sec_q <= a_disarmed;
                    else if (intrusion)
                    begin
                        sec_q <= a_alarm;
                        sec_start <= 1'b1;
                        sec_len <= alarm_p;
                    end
                end
                a_alarm:
                begin
                    if (sw.key_cyl_turn || sw.key_cyl_unlock || sw.liftgate_key_unlock)
                    begin
                        sec_q <= a_disarmed;
                        sec_stop <= 1'b1;
                    end
                    else if (sec_done)
                        sec_q <= a_armed;
                end
            endcase
        end
    end

    // horn cadence, free while alarm is sounding
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            horn_q <= '0;
            horn_phase_q <= 1'b0;
        end
        else if (sec_q != a_alarm)
        begin
            horn_q <= '0;
            horn_phase_q <= 1'b0;
        end
        else if (tick)
        begin
            if (horn_q + ms_w'(1) >= horn_half_p)
            begin
                horn_q <= '0;
                horn_phase_q <= !horn_phase_q;
            end
            else
                horn_q <= horn_q + ms_w'(1);
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            alarm_out <= '0;
        else
        begin
            alarm_out.horn <= (sec_q == a_alarm) && !horn_phase_q;
            alarm_out.headlights <= (sec_q == a_alarm) && !horn_phase_q;
            alarm_out.starter_block <= (sec_q == a_alarm);
            alarm_out.arming_indicator <= (sec_q == a_indicating) && sec_running;
            // same qualifier as the indicator so lock never leads or trails it
            alarm_out.central_lock_cmd <= (sec_q == a_indicating) && sec_running;
        end
    end
endmodule

// ==== bta_assertions.sv ====
`timescale 1ns/1ps
module bta_assertions
    import body_pkg::*;
#(
    parameter logic [ms_w-1:0] horn_half_p = ms_w'(horn_half_ms),
    parameter logic [ms_w-1:0] alarm_p = ms_w'(alarm_ms),
    parameter int unsigned tick_div_p = tick_div
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire sw_t sw_raw,
    input wire ev_t ev_raw,
    input wire logic wiper_drive_output,
    input wire alarm_out_t alarm_out
);
    // longint: the default alarm length in cycles overflows an int
    localparam longint half_c = longint'(horn_half_p) * tick_div_p;
    localparam longint alarm_c = longint'(alarm_p) * tick_div_p;
    logic [39:0] gap_q;
    logic [39:0] on_q;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            gap_q <= '0;
        else if ($changed(alarm_out.horn) || !alarm_out.starter_block)
            gap_q <= '0;
        else
            gap_q <= gap_q + 40'h1;
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            on_q <= '0;
        else if (!alarm_out.starter_block)
            on_q <= '0;
        else
            on_q <= on_q + 40'h1;
    end
    sequence s_alarm_rise;
        $rose(alarm_out.starter_block);
    endsequence
    sequence s_alarm_hold;
        alarm_out.starter_block [*8];
    endsequence
    AST_HORN_NEEDS_ALARM: assert property (alarm_out.horn |-> alarm_out.starter_block)
        else $error("horn without starter block");
    AST_LIGHTS_NEED_ALARM: assert property (alarm_out.headlights |-> alarm_out.starter_block)
        else $error("headlights without starter block");
    AST_HORN_PULSES: assert property (alarm_out.starter_block |-> gap_q <= half_c + tick_div_p)
        else $error("horn not toggling in alarm");
    AST_ALARM_BOUNDED: assert property (alarm_out.starter_block |-> on_q <= alarm_c + tick_div_p)
        else $error("alarm longer than its period");
    AST_RELEASE: assert property ($fell(alarm_out.starter_block) |-> !alarm_out.horn)
        else $error("horn left on after alarm");
    AST_CENTRAL_LOCK: assert property (alarm_out.central_lock_cmd |-> alarm_out.arming_indicator)
        else $error("central lock outside arming");
    AST_NO_ARM_IN_ALARM: assert property (alarm_out.arming_indicator |-> !alarm_out.starter_block)
        else $error("indicator during alarm");
    AST_ALARM_HOLDS: assert property (s_alarm_rise |-> s_alarm_hold)
        else $error("alarm dropped at once");
    AST_INDICATOR_HOLDS: assert property ($rose(alarm_out.arming_indicator) |-> alarm_out.arming_indicator [*8])
        else $error("indicator dropped at once");
    AST_WASH_GATED: assert property ($rose(wiper_drive_output) |->
        (sw_raw.ign_run || sw_raw.ignition_aux_position) && (sw_raw.wiper_off || sw_raw.wiper_periodic))
        else $error("wiper started outside allowed modes");
endmodule

bind body_timer_alarm_control bta_assertions #(.horn_half_p(horn_half_p), .alarm_p(alarm_p),
    .tick_div_p(tick_div_p)) chk_u (.clk(clk), .arst_n(arst_n), .sw_raw(sw_raw),
    .ev_raw(ev_raw), .wiper_drive_output(wiper_drive_output), .alarm_out(alarm_out));

// ==== ms_timer.sv ====
`timescale 1ns/1ps
module ms_timer
    import body_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tick,
    input wire logic start,
    input wire logic stop,
    input wire logic [ms_w-1:0] len_ms,
    output logic running,
    output logic done
);
    logic [ms_w-1:0] cnt_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_q <= '0;
            running <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (stop)
            begin
                running <= 1'b0;
                cnt_q <= '0;
            end
            else if (start)
            begin
                running <= 1'b1;
                cnt_q <= len_ms;
            end
            else if (running && tick)
            begin
                if (cnt_q <= ms_w'(1))
                begin
                    running <= 1'b0;
                    done <= 1'b1;
                    cnt_q <= '0;
                end
                else
                begin
                    cnt_q <= cnt_q - ms_w'(1);
                end
            end
        end
    end
endmodule

// ==== switch_filter.sv ====
`timescale 1ns/1ps
module switch_filter
    import body_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic tick,
    input wire logic raw,
    output logic clean
);
    logic s1_q;
    logic s2_q;
    logic [ms_w-1:0] stable_q;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
        end
        else
        begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end

    // state must hold steady for the debounce time before it is taken
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stable_q <= '0;
            clean <= 1'b0;
        end
        else if (s2_q == clean)
        begin
            stable_q <= '0;
        end
        else if (tick)
        begin
            if (stable_q >= ms_w'(debounce_ms))
            begin
                clean <= s2_q;
                stable_q <= '0;
            end
            else
            begin
                stable_q <= stable_q + ms_w'(1);
            end
        end
    end
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
    import body_pkg::*;
    localparam int unsigned div_c = 10;
    localparam logic [ms_w-1:0] mist_c = 18'h3C;
    localparam logic [ms_w-1:0] wipe_c = 18'h78;
    localparam logic [ms_w-1:0] after_c = 18'h12C;
    localparam logic [ms_w-1:0] arm_c = 18'hC8;
    localparam logic [ms_w-1:0] alarm_c = 18'h190;
    localparam logic [ms_w-1:0] horn_c = 18'h32;
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    sw_t sw = '0;
    ev_t ev = '0;
    sw_t sw_raw;
    ev_t ev_raw;
    logic wiper_drive_output;
    alarm_out_t alarm_out;
    int n_fail = 0;
    int total_checks = 0;
    int cyc = 0;
    initial forever #2.5 clk = ~clk;
    veh_model veh_u (.clk(clk), .sw_cmd(sw), .ev_cmd(ev), .sw_raw(sw_raw), .ev_raw(ev_raw));
    // ms figures scaled down tenfold (arm light 100x, alarm 450x), one ms is div_c cycles
    body_timer_alarm_control #(.mist_limit_p(mist_c), .wipe_cycle_p(wipe_c),
        .after_wash_p(after_c), .arm_light_p(arm_c), .alarm_p(alarm_c),
        .horn_half_p(horn_c), .tick_div_p(div_c)) dut_u (.clk(clk), .arst_n(arst_n),
        .sw_raw(sw_raw), .ev_raw(ev_raw), .wiper_drive_output(wiper_drive_output),
        .alarm_out(alarm_out));
    task automatic ms(input int n);
        repeat (n * div_c) @(posedge clk);
    endtask
    // seen is taken at the call edge, i.e. the value settled since the last edge
    task automatic chk(input string what, input logic seen, input logic exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %b seen %b", what, exp, seen);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 80000)
        begin
            n_fail++;
            results();
        end
    end
    task automatic do_reset;
        @(posedge clk);
        arst_n <= 1'h0;
        sw <= '0;
        ev <= '0;
        repeat (10) @(posedge clk);
        arst_n <= 1'h1;
        ms(15);
    endtask
    task automatic press(input int n);
        sw.washer <= 1'h1;
        ms(n);
        sw.washer <= 1'h0;
    endtask
    task automatic arm(input logic kl);
        ev.liftgate_open <= 1'h1;
        sw.door_open <= 1'h1;
        ms(20);
        sw.door_open <= 1'h0;
        sw.door_locked <= 1'h1;
        {ev.keyless_lock, ev.key_lock} <= {kl, ~kl};
        ms(20);
        {ev.keyless_lock, ev.key_lock} <= 2'h0;
        ms(20);
    endtask
    task automatic finish_arm;
        chk("indicator on", alarm_out.arming_indicator, 1'h1);
        chk("central lock", alarm_out.central_lock_cmd, 1'h1);
        ev.hood_open <= 1'h1;
        ms(40);
        ev.hood_open <= 1'h0;
        ms(20);
        ev.liftgate_open <= 1'h0;
        ms(90);
        chk("indicator held", alarm_out.arming_indicator, 1'h1);
        ms(50);
        chk("indicator off", alarm_out.arming_indicator, 1'h0);
    endtask
    task automatic t_reset;
        do_reset();
        chk("wiper idle", wiper_drive_output, 1'h0);
        chk("alarm idle", |alarm_out, 1'h0);
        $display("test reset done");
    endtask
    task automatic t_refused;
        for (int i = 0; i < 2; i++)
        begin
            do_reset();
            sw.ign_run <= (i == 1);
            sw.wiper_off <= (i == 0);
            ms(20);
            press(30);
            repeat (10)
            begin
                ms(20);
                chk("wiper refused", wiper_drive_output, 1'h0);
            end
        end
        $display("test refused done");
    endtask
    task automatic t_mist;
        do_reset();
        sw.ignition_aux_position <= 1'h1;
        sw.wiper_off <= 1'h1;
        ms(20);
        press(30);
        ms(25);
        chk("mist delay", wiper_drive_output, 1'h0);
        ms(75);
        chk("mist wipe", wiper_drive_output, 1'h1);
        ms(90);
        chk("mist end", wiper_drive_output, 1'h0);
        $display("test mist done");
    endtask
    task automatic t_long;
        do_reset();
        sw.ign_run <= 1'h1;
        sw.wiper_periodic <= 1'h1;
        ms(20);
        sw.washer <= 1'h1;
        ms(50);
        chk("on delay", wiper_drive_output, 1'h0);
        ms(40);
        chk("wash wipe", wiper_drive_output, 1'h1);
        ms(60);
        sw.washer <= 1'h0;
        ms(250);
        chk("after wash", wiper_drive_output, 1'h1);
        ms(90);
        chk("after end", wiper_drive_output, 1'h0);
        $display("test long done");
    endtask
    task automatic t_alarm;
        do_reset();
        arm(1'h0);
        finish_arm();
        sw.door_open <= 1'h1;
        ms(30);
        chk("starter block", alarm_out.starter_block, 1'h1);
        ms(100);
        chk("alarm on", alarm_out.starter_block, 1'h1);
        sw.key_cyl_turn <= 1'h1;
        ms(30);
        chk("alarm stop", alarm_out.starter_block, 1'h0);
        chk("horn stop", alarm_out.horn, 1'h0);
        $display("test alarm done");
    endtask
    task automatic t_retrigger;
        do_reset();
        arm(1'h1);
        finish_arm();
        ev.hood_open <= 1'h1;
        ms(30);
        chk("hood alarm", alarm_out.starter_block, 1'h1);
        ms(400);
        chk("period end", alarm_out.starter_block, 1'h0);
        chk("lights off", alarm_out.headlights, 1'h0);
        ev.hood_open <= 1'h0;
        ms(20);
        ev.liftgate_open <= 1'h1;
        ms(30);
        chk("second alarm", alarm_out.starter_block, 1'h1);
        sw.liftgate_key_unlock <= 1'h1;
        ms(30);
        chk("liftgate stop", alarm_out.starter_block, 1'h0);
        sw.door_open <= 1'h1;
        ms(40);
        chk("disarmed", alarm_out.starter_block, 1'h0);
        $display("test retrigger done");
    endtask
    task automatic t_disarm;
        for (int i = 0; i < 2; i++)
        begin
            do_reset();
            arm(1'h0);
            finish_arm();
            if (i == 0)
                sw.key_cyl_unlock <= 1'h1;
            else
                {sw.key_present, sw.ign_run} <= 2'h3;
            ms(30);
            sw.key_cyl_unlock <= 1'h0;
            sw.door_open <= 1'h1;
            ms(40);
            chk("no alarm", alarm_out.starter_block, 1'h0);
        end
        $display("test disarm done");
    endtask
    task automatic t_refuse;
        do_reset();
        arm(1'h0);
        sw.key_cyl_unlock <= 1'h1;
        ms(30);
        chk("abandoned", alarm_out.arming_indicator, 1'h0);
        sw.key_cyl_unlock <= 1'h0;
        ms(250);
        ev.hood_open <= 1'h1;
        ms(30);
        chk("not armed", alarm_out.starter_block, 1'h0);
        do_reset();
        sw.door_open <= 1'h1;
        ms(20);
        sw.door_locked <= 1'h1;
        ev.keyless_lock <= 1'h1;
        ms(20);
        ev.keyless_lock <= 1'h0;
        ms(20);
        chk("ajar refused", alarm_out.arming_indicator, 1'h0);
        ms(250);
        ev.hood_open <= 1'h1;
        ms(30);
        chk("ajar no alarm", alarm_out.starter_block, 1'h0);
        $display("test refuse done");
    endtask
    initial
    begin
        t_reset();
        t_refused();
        t_mist();
        t_long();
        t_alarm();
        t_retrigger();
        t_disarm();
        t_refuse();
        results();
    end
endmodule

// ==== veh_model.sv ====
`timescale 1ns/1ps
module veh_model
    import body_pkg::*;
(
    input wire logic clk,
    input wire sw_t sw_cmd,
    input wire ev_t ev_cmd,
    output sw_t sw_raw,
    output ev_t ev_raw
);
    logic [4:0] bounce_q = 5'h00;
    sw_t sw_q = '0;
    ev_t ev_q = '0;
    // contacts chatter about 2 ms after each change, well inside the filter
    always_ff @(posedge clk)
    begin
        if (bounce_q != 5'h00)
            bounce_q <= bounce_q - 5'h01;
        else if ({sw_cmd, ev_cmd} != {sw_q, ev_q})
            bounce_q <= 5'h14;
        if (bounce_q == 5'h01)
            {sw_q, ev_q} <= {sw_cmd, ev_cmd};
    end
    assign {sw_raw, ev_raw} = bounce_q[1] ? {sw_q, ev_q} : {sw_cmd, ev_cmd};
endmodule
